// ===== shared/vpat_cfg.svh
// Register indices, field positions, reset values and serial frame layout
`ifndef VPAT_CFG_SVH
`define VPAT_CFG_SVH

// Register indices on the serial port
`define IDX_A_REP_THIRD    5'h00
`define IDX_A_REP_FOURTH   5'h01
`define IDX_B_REP_ODD      5'h02
`define IDX_C_REP_ODD      5'h03
`define IDX_D_REP_ODD      5'h04
`define IDX_B_REP_EVEN     5'h05
`define IDX_C_REP_EVEN     5'h06
`define IDX_D_REP_EVEN     5'h07
`define IDX_HOLD_1         5'h08
`define IDX_RESTART_1      5'h0c
`define IDX_FINAL_LEN_A    5'h10
`define IDX_EXTRA_TOG_A    5'h14
`define IDX_A_REP_MAIN     5'h18
`define IDX_CTRL           5'h19
`define REG_COUNT          26
`define REG_COUNT_ADDR     8'h1a
`define REG_WIDTH          13
`define REG_RESET          13'h0000

// Control register bit positions
`define CTRL_MASK_BIT      0
`define CTRL_SEQ_ALT_BIT   1
`define CTRL_ALT_MAP_BIT   2
`define CTRL_FINAL_LEN_BIT 3
`define CTRL_EXTRA_TOG_BIT 4

// Select word layout: hold supplies the low part, restart the high part
`define ALT_LOW_WIDTH      13
`define ALT_HIGH_WIDTH     5
`define ALT_SEGMENTS       5'h12

// Serial frame: 8 address bits then 16 data bits, LSB first
`define FRAME_BITS         5'h18
`define ADDR_LSB           0
`define ADDR_MSB           7
`define DATA_LSB           8
`define DATA_MSB           20

`endif

// ===== shared/vpat_pkg.sv
// Types shared by the vertical pattern repeat and freeze register block
package vpat_pkg;
`include "vpat_cfg.svh"

   // Kind of line in the four-line cycle, Gray coded
   typedef enum logic [1:0] {
      LINE_ODD    = 2'h0,
      LINE_EVEN   = 2'h1,
      LINE_THIRD  = 2'h3,
      LINE_FOURTH = 2'h2
   } line_kind_t;

   typedef struct packed {
      logic [12:0] a;
      logic [12:0] b;
      logic [12:0] c;
      logic [12:0] d;
   } group_word_t;

   typedef struct packed {
      logic [17:0] low_even;
      logic [17:0] high_even;
      logic [17:0] low_odd;
      logic [17:0] high_odd;
   } alt_select_t;

   typedef struct packed {
      logic load_n;
      logic sclk;
      logic sdata;
   } serial_pins_t;

   typedef struct packed {
      serial_pins_t                            sync1;
      serial_pins_t                            sync2;
      logic                                    sclk_prev;
      logic                                    load_prev;
      logic [23:0]                             shift;
      logic [4:0]                              bit_count;
      logic [`REG_COUNT-1:0][`REG_WIDTH-1:0]   regs;
      logic [3:0]                              pair;
      logic                                    freeze;
      group_word_t                             rep;
      group_word_t                             final_len;
      group_word_t                             extra_toggle;
      logic                                    final_len_valid;
      logic                                    extra_toggle_valid;
      logic                                    seq_alt_active;
      alt_select_t                             alt_sel;
      logic [1:0]                              segment_group;
   } vpat_state_t;
endpackage

// ===== rtl/vpat_repeat_freeze.sv
// Vertical pattern repeat counts, freeze window and alternation select words
`timescale 1ns/100ps
`default_nettype none
`include "vpat_cfg.svh"

// Summary of operation
// - Group A repeats for third, fourth lines
// - Groups B, C, D repeats on odd lines
// - Separate B, C, D repeats on even lines
// - Masking holds outputs from hold pixel
// - Masking resumes outputs at restart pixel
// - Hold fields give select word bits 12:0
// - Restart fields give select bits 17:13
// - Final repetition length used when enabled
// - Fifth toggle position used when enabled
// - Fifth toggle shared by all outputs
// - Alternation mode entered when bit set
// - Select bit pair picks groups A to D
module vpat_repeat_freeze (
   // Clock and reset
   input  wire logic                 sys_clk_i,
   input  wire logic                 nrst_i,
   // Three-wire serial register port
   input  wire logic                 ser_load_n_i,
   input  wire logic                 ser_clk_i,
   input  wire logic                 ser_data_i,
   // Position within the vertical sequence
   input  wire logic [12:0]          pixel_count_i,
   input  wire vpat_pkg::line_kind_t  line_kind_i,
   input  wire logic [4:0]           segment_index_i,
   // Values handed to the pattern generator
   output vpat_pkg::group_word_t     rep_count_o,
   output logic                      freeze_o,
   output logic                      seq_alt_active_o,
   output vpat_pkg::alt_select_t     alt_select_o,
   output logic [1:0]                segment_group_o,
   output vpat_pkg::group_word_t     final_len_o,
   output logic                      final_len_valid_o,
   output vpat_pkg::group_word_t     extra_toggle_o,
   output logic                      extra_toggle_valid_o
);

   vpat_pkg::vpat_state_t q;
   vpat_pkg::vpat_state_t next_q;

   // Pixel position match, used for every hold and restart compare
   function automatic logic pos_hit(input logic [12:0] pos, input logic [12:0] mark);
      return pos == mark;
   endfunction

   // Even-side lines: the fourth line shares the even words
   function automatic logic is_even(input vpat_pkg::line_kind_t kind);
      return (kind == vpat_pkg::LINE_EVEN) || (kind == vpat_pkg::LINE_FOURTH);
   endfunction

   // Two-bit group code of one segment; beyond the last segment it falls back to A
   function automatic logic [1:0] seg_code(input logic [17:0] sel0,
                                           input logic [17:0] sel1,
                                           input logic [4:0]  idx);
      logic [1:0] code;
      code = 2'h0;
      if (idx < `ALT_SEGMENTS) begin
         code = {sel0[idx], sel1[idx]};
      end
      return code;
   endfunction

   logic [12:0] ctrl_word;
   logic        mask_en;
   logic        seq_alt_en;
   logic        final_len_en;
   logic        extra_tog_en;
   logic [7:0]  wr_addr;
   logic        sclk_rise;
   logic        load_end;

   // Decoded control bits and serial strobes, taken only from second sync stage
   always_comb begin
      ctrl_word    = q.regs[`IDX_CTRL];
      mask_en      = ctrl_word[`CTRL_MASK_BIT];
      seq_alt_en   = ctrl_word[`CTRL_SEQ_ALT_BIT];
      final_len_en = ctrl_word[`CTRL_FINAL_LEN_BIT];
      extra_tog_en = ctrl_word[`CTRL_EXTRA_TOG_BIT];
      wr_addr      = q.shift[`ADDR_MSB:`ADDR_LSB];
      sclk_rise    = q.sync2.sclk && !q.sclk_prev;
      load_end     = q.sync2.load_n && !q.load_prev;
   end

   // Next state of the whole block
   always_comb begin
      next_q = q;

      // Pins come from another domain, so two stages before any use
      next_q.sync1     = '{load_n: ser_load_n_i, sclk: ser_clk_i, sdata: ser_data_i};
      next_q.sync2     = q.sync1;
      next_q.sclk_prev = q.sync2.sclk;
      next_q.load_prev = q.sync2.load_n;

      // Shift while load is low; a frame shorter than 24 bits is dropped, a longer one keeps its last 24 bits
      if (!q.sync2.load_n) begin
         if (sclk_rise) begin
            next_q.shift = {q.sync2.sdata, q.shift[23:1]};
            if (q.bit_count != `FRAME_BITS) begin
               next_q.bit_count = q.bit_count + 5'h01;
            end
         end
      end else begin
         next_q.bit_count = 5'h00;
         if (load_end && (q.bit_count == `FRAME_BITS) && (wr_addr < `REG_COUNT_ADDR)) begin
            next_q.regs[wr_addr[4:0]] = q.shift[`DATA_MSB:`DATA_LSB];
         end
      end

      next_q.seq_alt_active = seq_alt_en;

      // group A count by line kind
      unique case (line_kind_i)
         vpat_pkg::LINE_THIRD:  next_q.rep.a = q.regs[`IDX_A_REP_THIRD];
         vpat_pkg::LINE_FOURTH: next_q.rep.a = q.regs[`IDX_A_REP_FOURTH];
         default:               next_q.rep.a = q.regs[`IDX_A_REP_MAIN];
      endcase

      // odd and even counts held apart for B, C, D
      if (is_even(line_kind_i)) begin
         next_q.rep.b = q.regs[`IDX_B_REP_EVEN];
         next_q.rep.c = q.regs[`IDX_C_REP_EVEN];
         next_q.rep.d = q.regs[`IDX_D_REP_EVEN];
      end else begin
         next_q.rep.b = q.regs[`IDX_B_REP_ODD];
         next_q.rep.c = q.regs[`IDX_C_REP_ODD];
         next_q.rep.d = q.regs[`IDX_D_REP_ODD];
      end

      // one hold window per pair; hold wins when both match
      for (int k = 0; k < 4; k++) begin
         if (mask_en && !seq_alt_en) begin
            if (pos_hit(pixel_count_i, q.regs[`IDX_HOLD_1 + 5'(k)])) begin
               next_q.pair[k] = 1'b1;
            end else if (pos_hit(pixel_count_i, q.regs[`IDX_RESTART_1 + 5'(k)])) begin
               next_q.pair[k] = 1'b0;
            end
         end else begin
            next_q.pair[k] = 1'b0;
         end
      end
      next_q.freeze = |next_q.pair;

      // fields re-read as select words, zero outside the mode
      if (seq_alt_en) begin
         next_q.alt_sel.low_even  = {q.regs[`IDX_RESTART_1][`ALT_HIGH_WIDTH-1:0],
                                     q.regs[`IDX_HOLD_1]};
         next_q.alt_sel.high_even = {q.regs[`IDX_RESTART_1 + 5'h01][`ALT_HIGH_WIDTH-1:0],
                                     q.regs[`IDX_HOLD_1 + 5'h01]};
         next_q.alt_sel.low_odd   = {q.regs[`IDX_RESTART_1 + 5'h02][`ALT_HIGH_WIDTH-1:0],
                                     q.regs[`IDX_HOLD_1 + 5'h02]};
         next_q.alt_sel.high_odd  = {q.regs[`IDX_RESTART_1 + 5'h03][`ALT_HIGH_WIDTH-1:0],
                                     q.regs[`IDX_HOLD_1 + 5'h03]};
      end else begin
         next_q.alt_sel = '0;
      end

      // group code of the current segment for this line parity
      if (is_even(line_kind_i)) begin
         next_q.segment_group = seg_code(next_q.alt_sel.low_even,
                                         next_q.alt_sel.high_even, segment_index_i);
      end else begin
         next_q.segment_group = seg_code(next_q.alt_sel.low_odd,
                                         next_q.alt_sel.high_odd, segment_index_i);
      end

      // final length passed on only while enabled
      next_q.final_len_valid = final_len_en;
      if (final_len_en) begin
         next_q.final_len = {q.regs[`IDX_FINAL_LEN_A], q.regs[`IDX_FINAL_LEN_A + 5'h01],
                             q.regs[`IDX_FINAL_LEN_A + 5'h02], q.regs[`IDX_FINAL_LEN_A + 5'h03]};
      end else begin
         next_q.final_len = '0;
      end

      // one fifth toggle per group, common to every output
      next_q.extra_toggle_valid = extra_tog_en;
      if (extra_tog_en) begin
         next_q.extra_toggle = {q.regs[`IDX_EXTRA_TOG_A], q.regs[`IDX_EXTRA_TOG_A + 5'h01],
                                q.regs[`IDX_EXTRA_TOG_A + 5'h02],
                                q.regs[`IDX_EXTRA_TOG_A + 5'h03]};
      end else begin
         next_q.extra_toggle = '0;
      end
   end

   // State register; everything clears to zero except the load sync stages and load_prev, which
   // start at the pin's idle high level so no false load edge follows reset
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q                <= '0;
         q.sync1.load_n   <= 1'b1;
         q.sync2.load_n   <= 1'b1;
         q.load_prev      <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from the state flops
   assign rep_count_o          = q.rep;
   assign freeze_o             = q.freeze;
   assign seq_alt_active_o     = q.seq_alt_active;
   assign alt_select_o         = q.alt_sel;
   assign segment_group_o      = q.segment_group;
   assign final_len_o          = q.final_len;
   assign final_len_valid_o    = q.final_len_valid;
   assign extra_toggle_o       = q.extra_toggle;
   assign extra_toggle_valid_o = q.extra_toggle_valid;

   // Checks on the block's own outputs and internal signals
   default clocking chk_clk @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   rep_third_a: assert property (
      line_kind_i == vpat_pkg::LINE_THIRD |=> rep_count_o.a == $past(q.regs[`IDX_A_REP_THIRD]))
      else $error("group A third-line count not applied");

   rep_odd_a: assert property (
      line_kind_i == vpat_pkg::LINE_ODD |=> rep_count_o.c == $past(q.regs[`IDX_C_REP_ODD]))
      else $error("group C odd-line count not applied");

   rep_even_a: assert property (
      line_kind_i == vpat_pkg::LINE_EVEN |=> rep_count_o.b == $past(q.regs[`IDX_B_REP_EVEN]))
      else $error("group B even-line count not applied");

   hold_start_a: assert property (
      mask_en && !seq_alt_en && pixel_count_i == q.regs[`IDX_HOLD_1] |=> freeze_o)
      else $error("outputs not held at hold pixel");

   restart_pair_a: assert property (
      mask_en && !seq_alt_en && pixel_count_i == q.regs[`IDX_RESTART_1 + 5'h02]
      && pixel_count_i != q.regs[`IDX_HOLD_1 + 5'h02] |=> !q.pair[2])
      else $error("hold window 3 not released at restart pixel");

   alt_low_bits_a: assert property (
      seq_alt_en |=> alt_select_o.low_odd[12:0] == $past(q.regs[`IDX_HOLD_1 + 5'h02]))
      else $error("select word low bits wrong");

   alt_high_bits_a: assert property (
      seq_alt_en |=> alt_select_o.high_even[17:13] == $past(q.regs[`IDX_RESTART_1 + 5'h01][4:0]))
      else $error("select word high bits wrong");

   final_len_gate_a: assert property (
      !final_len_en |=> !final_len_valid_o && final_len_o == '0)
      else $error("final length passed while disabled");

   extra_tog_a: assert property (
      extra_tog_en |=> extra_toggle_valid_o
      && extra_toggle_o.d == $past(q.regs[`IDX_EXTRA_TOG_A + 5'h03]))
      else $error("fifth toggle position not passed");

   mode_entry_a: assert property (
      $rose(seq_alt_en) |=> seq_alt_active_o ##1 seq_alt_active_o || !seq_alt_en)
      else $error("alternation mode not entered");

   seg_code_a: assert property (
      seq_alt_en && !is_even(line_kind_i) && segment_index_i == 5'h00 |=>
      segment_group_o == {$past(q.regs[`IDX_HOLD_1 + 5'h02][0]),
                          $past(q.regs[`IDX_HOLD_1 + 5'h03][0])})
      else $error("segment group code wrong");

   no_freeze_alt_a: assert property (
      seq_alt_en [*2] |-> !freeze_o)
      else $error("freeze active in alternation mode");

   freeze_seen_c: cover property (mask_en && !seq_alt_en ##1 freeze_o ##[1:20] !freeze_o);
   alt_group_d_c: cover property (seq_alt_en ##1 segment_group_o == 2'h3);
   reg_write_c:   cover property (load_end && q.bit_count == `FRAME_BITS);
   final_len_c:   cover property (final_len_valid_o && extra_toggle_valid_o);

endmodule // vpat_repeat_freeze
`default_nettype wire

// ===== sim/vpat_serial_host.sv
// Serial register host model that writes frames on the three-wire port
`timescale 1ns/100ps
`default_nettype none
module vpat_serial_host (
   // Clock
   input  wire logic sys_clk_i,
   // Serial pins toward the block
   output logic      ser_load_n_o,
   output logic      ser_clk_o,
   output logic      ser_data_o
);
   // Idle: load high, serial clock parked low
   initial begin
      ser_load_n_o = 1'b1;
      ser_clk_o    = 1'b0;
      ser_data_o   = 1'b0;
   end

   // One frame: 8 address bits then 16 data bits, LSB first.
   // Each clock phase lasts 4 cycles so the 2-FF sync never misses an edge.
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      logic [23:0] frame;
      frame = {data, addr};
      @(posedge sys_clk_i) ser_load_n_o <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         @(posedge sys_clk_i);
         ser_data_o <= frame[i];
         ser_clk_o  <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
         ser_clk_o  <= 1'b1;
         repeat (3) @(posedge sys_clk_i);
      end
      @(posedge sys_clk_i) ser_clk_o <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      // Data line no longer meaningful: show the inverse, not a stale bit
      ser_load_n_o <= 1'b1;
      ser_data_o   <= ~ser_data_o;
      repeat (4) @(posedge sys_clk_i);
   endtask
endmodule // vpat_serial_host
`default_nettype wire

// ===== sim/vpat_repeat_freeze_tb_top.sv
// Self-checking bench for the vertical pattern repeat and freeze block
`timescale 1ns/100ps
`default_nettype none
module vpat_repeat_freeze_tb_top;
   logic                  sys_clk = 1'b0;
   logic                  nrst    = 1'b0;
   logic                  load_n, sclk, sdata;
   logic [12:0]           pixel   = 13'h0000;
   vpat_pkg::line_kind_t  kind    = vpat_pkg::LINE_ODD;
   logic [4:0]            seg     = 5'h00;
   vpat_pkg::group_word_t rep, flen, xtog;
   vpat_pkg::alt_select_t alt;
   logic                  frz, salt, fval, xval;
   logic [1:0]            grp;
   int                    bad_count   = 0;
   int                    check_count = 0;

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   vpat_serial_host host_u (
      .sys_clk_i(sys_clk), .ser_load_n_o(load_n), .ser_clk_o(sclk), .ser_data_o(sdata));

   vpat_repeat_freeze dut_u (
      .sys_clk_i(sys_clk), .nrst_i(nrst), .ser_load_n_i(load_n), .ser_clk_i(sclk),
      .ser_data_i(sdata), .pixel_count_i(pixel), .line_kind_i(kind),
      .segment_index_i(seg), .rep_count_o(rep), .freeze_o(frz), .seq_alt_active_o(salt),
      .alt_select_o(alt), .segment_group_o(grp), .final_len_o(flen),
      .final_len_valid_o(fval), .extra_toggle_o(xtog), .extra_toggle_valid_o(xval));

   task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Top data bits set on purpose: the block must drop bits 15:13
   task automatic wr(input logic [7:0] addr, input logic [12:0] val);
      host_u.write_reg(addr, {3'h7, val});
      repeat (4) @(posedge sys_clk);
   endtask

   // Inputs land at one edge and outputs at the next; looking two edges later
   // keeps the compare clear of the edge that launches the value
   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic t_reset();
      chk("reset words", 72'h0, 72'({rep, 2'h0, grp}));
      chk("reset alt", 72'h0, alt);
      chk("reset flags", 72'h0, 72'({frz, salt, fval, xval}));
      chk("reset final", 72'h0, 72'(flen));
      chk("reset extra", 72'h0, 72'(xtog));
   endtask

   task automatic kchk(input vpat_pkg::line_kind_t k, input logic [51:0] e, input string n);
      kind <= k;
      settle();
      chk(n, 72'(e), 72'(rep));
   endtask

   task automatic t_repeat();
      for (int i = 0; i < 8; i++) wr(i[7:0], 13'h00a0 + i[12:0]);
      wr(8'h18, 13'h1fff);
      kchk(vpat_pkg::LINE_ODD, {13'h1fff, 13'h00a2, 13'h00a3, 13'h00a4}, "rep odd");
      kchk(vpat_pkg::LINE_EVEN, {13'h1fff, 13'h00a5, 13'h00a6, 13'h00a7}, "rep even");
      kchk(vpat_pkg::LINE_THIRD, {13'h00a0, 13'h00a2, 13'h00a3, 13'h00a4}, "rep 3rd");
      kchk(vpat_pkg::LINE_FOURTH, {13'h00a1, 13'h00a5, 13'h00a6, 13'h00a7}, "rep 4th");
   endtask

   task automatic pix(input logic [12:0] p, input logic e, input string n);
      pixel <= p;
      settle();
      chk(n, 72'(e), 72'(frz));
   endtask

   // Pixel kept off every programmed position before masking goes on
   task automatic t_freeze();
      pixel <= 13'd99;
      wr(8'h08, 13'd100);
      wr(8'h0c, 13'd200);
      wr(8'h0a, 13'd300);
      wr(8'h0e, 13'd400);
      wr(8'h19, 13'h0001);
      pix(13'd99, 1'b0, "freeze early");
      pix(13'd100, 1'b1, "freeze hold");
      pix(13'd150, 1'b1, "freeze stays");
      pix(13'd200, 1'b0, "freeze resume");
      pix(13'd300, 1'b1, "freeze hold 3");
      pix(13'd400, 1'b0, "freeze resume 3");
      pix(13'd100, 1'b1, "freeze again");
      wr(8'h19, 13'h0000);
      chk("freeze unmasked", 72'h0, 72'(frz));
   endtask

   task automatic t_final();
      // each final length is written as that group's pattern length
      for (int i = 0; i < 4; i++) begin
         wr(8'h10 + i[7:0], 13'h0300 + i[12:0]);
         wr(8'h14 + i[7:0], 13'h0400 + i[12:0]);
      end
      chk("final off", 72'h0, 72'({fval, flen}));
      chk("extra off", 72'h0, 72'({xval, xtog}));
      wr(8'h19, 13'h0018);
      chk("final on", 72'({1'b1, 13'h0300, 13'h0301, 13'h0302, 13'h0303}),
          72'({fval, flen}));
      chk("extra on", 72'({1'b1, 13'h0400, 13'h0401, 13'h0402, 13'h0403}),
          72'({xval, xtog}));
   endtask

   task automatic t_alt();
      logic [17:0] w [4];
      w = '{18'h2b555, 18'h10f0f, 18'h05234, 18'h3cabc};
      for (int k = 0; k < 4; k++) begin
         wr(8'h08 + k[7:0], w[k][12:0]);
         wr(8'h0c + k[7:0], {8'h00, w[k][17:13]});
      end
      pixel <= w[0][12:0];
      // map enable written together with alternation
      wr(8'h19, 13'h0007);
      settle();
      chk("alt mode", 72'h1, 72'(salt));
      chk("alt no freeze", 72'h0, 72'(frz));
      chk("alt words", {w[0], w[1], w[2], w[3]}, alt);
      for (int i = 0; i < 18; i++) begin
         kind <= vpat_pkg::LINE_EVEN;
         seg  <= i[4:0];
         settle();
         chk("seg even", 72'({w[0][i], w[1][i]}), 72'(grp));
         kind <= vpat_pkg::LINE_ODD;
         settle();
         chk("seg odd", 72'({w[2][i], w[3][i]}), 72'(grp));
      end
      seg <= 5'd18;
      settle();
      chk("seg beyond", 72'h0, 72'(grp));
      wr(8'h19, 13'h0000);
      chk("alt off", 72'h0, alt);
      chk("alt mode off", 72'h0, 72'(salt));
   endtask

   // Main sequence after six cycles of reset
   initial begin
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset();
      t_repeat();
      t_freeze();
      t_final();
      t_alt();
      stop_test();
   end

   // Hang guard: a run this long counts as a mismatch
   initial begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      stop_test();
   end
endmodule // vpat_repeat_freeze_tb_top
`default_nettype wire
